// *** hdl/cab_bridge.sv ***
// Purpose: Control word command to internal APB bridge with late answer handling
// Assumes: Command port on CLK_SYS, one command outstanding until answered
// Notes: Late reads keep running; data is collected later indirectly
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Late read answered with code from two-bit field: ignored, OK, fail.
// - Under OK setting the access keeps running; byte collected later indirectly.
// - New bridge access while APB still busy is answered with fail.
// - Bit 3 of timeout control disables the access timeout when set.
// - Three-bit field selects timeout of 8 to 512 or 65535 bus cycles.
// - Address of last completed bridge read latched in low and high registers.
// - Local register accesses never update the last-address latch.
// - Read-only byte holds data fetched from the latched address.
// - Any bridge read issued while the APB is idle clears the read-data-ready flag.
// - Late read sets last-late flag and pulses the late event.
module cab_bridge
#(
    parameter logic [15:0] TMO_MAX = cab_pkg::TMO_MAX_BUS
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Link clock pin
    input wire logic SW_CLK,
    // Command from control word decoder
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [15:0] CMD_ADDR,
    input wire logic [7:0] CMD_WDATA,
    // Answer to control word encoder
    output logic ANS_VALID,
    output logic [1:0] ANS_CODE,
    output logic [7:0] ANS_RDATA,
    // APB master
    output logic PSEL,
    output logic PENABLE,
    output logic PWRITE,
    output logic [15:0] PADDR,
    output logic [7:0] PWDATA,
    input wire logic [7:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Events
    output logic LATE_EVT,
    output logic TIMEOUT_EVT
);
    cab_pkg::cab_state_type state_reg, state_next;
    logic [15:0] bus_cnt_reg, bus_cnt_next;
    logic psel_reg, psel_next, pen_reg, pen_next, pwrite_reg, pwrite_next;
    logic [15:0] paddr_reg, paddr_next;
    logic [7:0] pwdata_reg, pwdata_next;
    logic ans_valid_reg, ans_valid_next;
    logic [1:0] ans_code_reg, ans_code_next;
    logic [7:0] ans_rdata_reg, ans_rdata_next;
    logic late_evt_reg, late_evt_next, tmo_evt_reg, tmo_evt_next;
    logic [1:0] tardy_answer_code_reg, tardy_answer_code_next;
    logic tmo_dis_reg, tmo_dis_next;
    logic [2:0] tmo_sel_reg, tmo_sel_next;
    logic [15:0] last_addr_reg, last_addr_next;
    logic [7:0] fetched_reg, fetched_next;
    logic rdata_rdy_reg, rdata_rdy_next, done_reg, done_next;
    logic last_late_reg, last_late_next, wait_ans_reg, wait_ans_next;
    logic bus_rise;
    logic is_local;
    logic [7:0] local_rd;
    logic [15:0] tmo_limit;
    logic [1:0] late_code;

    cab_edge_sync u_clk_edge
    (
        .clk(CLK_SYS),
        .srst(SRST),
        .async_in(SW_CLK),
        .rise(bus_rise)
    );

    assign is_local = CMD_ADDR < cab_pkg::BRIDGE_START;
    // Reserved encoding falls back to fail
    assign late_code = (tardy_answer_code_reg == cab_pkg::ANS_RSVD) ? cab_pkg::ANS_FAIL
        : tardy_answer_code_reg;
    assign tmo_limit = (tmo_sel_reg == cab_pkg::TMO_SEL_MAX) ? TMO_MAX
        : 16'(cab_pkg::TMO_BASE_BUS << tmo_sel_reg);

    always_comb
    begin
        local_rd = 8'h00;
        if (CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_STATUS)
            local_rd = {4'h0, last_late_reg, state_reg != cab_pkg::ST_IDLE, done_reg,
                rdata_rdy_reg};
        else if (CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_TARDY)
            local_rd = {6'h00, tardy_answer_code_reg};
        else if (CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_TMO)
            local_rd = {4'h0, tmo_dis_reg, tmo_sel_reg};
        else if (CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_ADDR_LO)
            local_rd = last_addr_reg[7:0];
        else if (CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_ADDR_HI)
            local_rd = last_addr_reg[15:8];
        else if (CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_FETCHED)
            local_rd = fetched_reg;
    end

    always_comb
    begin
        state_next = state_reg;
        bus_cnt_next = bus_cnt_reg;
        psel_next = psel_reg;
        pen_next = pen_reg;
        pwrite_next = pwrite_reg;
        paddr_next = paddr_reg;
        pwdata_next = pwdata_reg;
        ans_valid_next = 1'b0;
        ans_code_next = ans_code_reg;
        ans_rdata_next = ans_rdata_reg;
        late_evt_next = 1'b0;
        tmo_evt_next = 1'b0;
        tardy_answer_code_next = tardy_answer_code_reg;
        tmo_dis_next = tmo_dis_reg;
        tmo_sel_next = tmo_sel_reg;
        last_addr_next = last_addr_reg;
        fetched_next = fetched_reg;
        rdata_rdy_next = rdata_rdy_reg;
        done_next = done_reg;
        last_late_next = last_late_reg;
        wait_ans_next = wait_ans_reg;
        // Saturate so a stalled link never wraps the count
        if (bus_rise && state_reg != cab_pkg::ST_IDLE && bus_cnt_reg != cab_pkg::TMO_MAX_BUS)
            bus_cnt_next = bus_cnt_reg + 16'h0001;
        // Commands are ignored while a read answer is still owed
        if (CMD_VALID && !wait_ans_reg)
        begin
            ans_valid_next = 1'b1;
            ans_code_next = cab_pkg::ANS_OK;
            ans_rdata_next = 8'h00;
            if (is_local)
            begin
                ans_rdata_next = CMD_WRITE ? 8'h00 : local_rd;
                if (CMD_WRITE && CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_TARDY)
                    tardy_answer_code_next = CMD_WDATA[cab_pkg::TARDY_MSB:0];
                if (CMD_WRITE && CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_TMO)
                begin
                    tmo_dis_next = CMD_WDATA[cab_pkg::TMO_DIS_BIT];
                    tmo_sel_next = CMD_WDATA[cab_pkg::TMO_SEL_MSB:0];
                end
            end
            else if (state_reg != cab_pkg::ST_IDLE)
                ans_code_next = cab_pkg::ANS_FAIL;
            else if (!CMD_WRITE && rdata_rdy_reg && CMD_ADDR == last_addr_reg)
            begin
                // Indirect collection of a late read
                ans_rdata_next = fetched_reg;
                rdata_rdy_next = 1'b0;
                done_next = 1'b0;
            end
            else
            begin
                state_next = cab_pkg::ST_SETUP;
                bus_cnt_next = 16'h0000;
                psel_next = 1'b1;
                pwrite_next = CMD_WRITE;
                paddr_next = CMD_ADDR;
                pwdata_next = CMD_WDATA;
                done_next = 1'b0;
                last_late_next = 1'b0;
                if (!CMD_WRITE)
                begin
                    // Read answer deferred until data or window end
                    ans_valid_next = 1'b0;
                    wait_ans_next = 1'b1;
                    rdata_rdy_next = 1'b0;
                end
            end
        end
        unique case (state_reg)
            cab_pkg::ST_IDLE:
            begin
            end
            cab_pkg::ST_SETUP:
            begin
                pen_next = 1'b1;
                state_next = cab_pkg::ST_ACCESS;
            end
            cab_pkg::ST_ACCESS:
            begin
                if (PREADY)
                begin
                    psel_next = 1'b0;
                    pen_next = 1'b0;
                    state_next = cab_pkg::ST_IDLE;
                    done_next = 1'b1;
                    if (!pwrite_reg)
                    begin
                        last_addr_next = paddr_reg;
                        fetched_next = PRDATA;
                        if (wait_ans_reg)
                        begin
                            ans_valid_next = 1'b1;
                            ans_code_next = PSLVERR ? cab_pkg::ANS_FAIL : cab_pkg::ANS_OK;
                            ans_rdata_next = PRDATA;
                            wait_ans_next = 1'b0;
                        end
                        else
                            rdata_rdy_next = 1'b1;
                    end
                end
                else if (wait_ans_reg && bus_cnt_reg >= cab_pkg::RESP_WIN_BUS)
                begin
                    // Access stays open in every late mode
                    ans_valid_next = 1'b1;
                    ans_code_next = late_code;
                    ans_rdata_next = 8'h00;
                    wait_ans_next = 1'b0;
                    last_late_next = 1'b1;
                    late_evt_next = 1'b1;
                end
                else if (!tmo_dis_reg && bus_cnt_reg >= tmo_limit)
                begin
                    psel_next = 1'b0;
                    pen_next = 1'b0;
                    state_next = cab_pkg::ST_IDLE;
                    tmo_evt_next = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            state_reg <= cab_pkg::ST_IDLE;
            bus_cnt_reg <= 16'h0000;
            psel_reg <= 1'b0;
            pen_reg <= 1'b0;
            pwrite_reg <= 1'b0;
            paddr_reg <= 16'h0000;
            pwdata_reg <= 8'h00;
            ans_valid_reg <= 1'b0;
            ans_code_reg <= cab_pkg::ANS_OK;
            ans_rdata_reg <= 8'h00;
            late_evt_reg <= 1'b0;
            tmo_evt_reg <= 1'b0;
            tardy_answer_code_reg <= cab_pkg::TARDY_RST;
            tmo_dis_reg <= cab_pkg::TMO_DIS_RST;
            tmo_sel_reg <= cab_pkg::TMO_SEL_RST;
            last_addr_reg <= 16'h0000;
            fetched_reg <= 8'h00;
            rdata_rdy_reg <= 1'b0;
            done_reg <= 1'b0;
            last_late_reg <= 1'b0;
            wait_ans_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            bus_cnt_reg <= bus_cnt_next;
            psel_reg <= psel_next;
            pen_reg <= pen_next;
            pwrite_reg <= pwrite_next;
            paddr_reg <= paddr_next;
            pwdata_reg <= pwdata_next;
            ans_valid_reg <= ans_valid_next;
            ans_code_reg <= ans_code_next;
            ans_rdata_reg <= ans_rdata_next;
            late_evt_reg <= late_evt_next;
            tmo_evt_reg <= tmo_evt_next;
            tardy_answer_code_reg <= tardy_answer_code_next;
            tmo_dis_reg <= tmo_dis_next;
            tmo_sel_reg <= tmo_sel_next;
            last_addr_reg <= last_addr_next;
            fetched_reg <= fetched_next;
            rdata_rdy_reg <= rdata_rdy_next;
            done_reg <= done_next;
            last_late_reg <= last_late_next;
            wait_ans_reg <= wait_ans_next;
        end
    end

    assign ANS_VALID = ans_valid_reg;
    assign ANS_CODE = ans_code_reg;
    assign ANS_RDATA = ans_rdata_reg;
    assign PSEL = psel_reg;
    assign PENABLE = pen_reg;
    assign PWRITE = pwrite_reg;
    assign PADDR = paddr_reg;
    assign PWDATA = pwdata_reg;
    assign LATE_EVT = late_evt_reg;
    assign TIMEOUT_EVT = tmo_evt_reg;

    a_busy_fail: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CMD_VALID && !wait_ans_reg && !is_local && state_reg != cab_pkg::ST_IDLE
        |=> ANS_VALID && ANS_CODE == cab_pkg::ANS_FAIL)
        else $error("busy bridge access not failed");
    a_late_code: assert property (@(posedge CLK_SYS) disable iff (SRST)
        $rose(last_late_reg) |-> ANS_VALID && ANS_CODE == $past(late_code))
        else $error("late answer code wrong");
    a_late_flag: assert property (@(posedge CLK_SYS) disable iff (SRST)
        LATE_EVT |-> last_late_reg && ANS_VALID && !wait_ans_reg)
        else $error("late event without flag");
    a_late_keeps: assert property (@(posedge CLK_SYS) disable iff (SRST)
        LATE_EVT |-> PSEL && PENABLE)
        else $error("late read access dropped");
    a_tmo_disable: assert property (@(posedge CLK_SYS) disable iff (SRST)
        TIMEOUT_EVT |-> !$past(tmo_dis_reg))
        else $error("timeout while disabled");
    a_tmo_count: assert property (@(posedge CLK_SYS) disable iff (SRST)
        TIMEOUT_EVT |-> $past(bus_cnt_reg) == $past(tmo_limit))
        else $error("timeout at wrong count");
    a_tmo_free: assert property (@(posedge CLK_SYS) disable iff (SRST)
        TIMEOUT_EVT |-> !PSEL && !PENABLE && state_reg == cab_pkg::ST_IDLE)
        else $error("timeout left access open");
    a_addr_latch: assert property (@(posedge CLK_SYS) disable iff (SRST)
        state_reg == cab_pkg::ST_ACCESS && PREADY && !PWRITE
        |=> last_addr_reg == $past(PADDR) && fetched_reg == $past(PRDATA))
        else $error("read address not latched");
    a_local_keep: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CMD_VALID && is_local && state_reg == cab_pkg::ST_IDLE |=> $stable(last_addr_reg))
        else $error("local access moved latch");
    a_rdy_clear: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CMD_VALID && !wait_ans_reg && !is_local && !CMD_WRITE
        && state_reg == cab_pkg::ST_IDLE |=> !rdata_rdy_reg)
        else $error("bridge read kept ready flag");
    a_rsvd_zero: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CMD_VALID && !wait_ans_reg && !CMD_WRITE
        && CMD_ADDR == cab_pkg::REG_BASE + cab_pkg::OFS_TMO |=> ANS_RDATA[7:4] == 4'h0)
        else $error("reserved bits not zero");
endmodule // cab_bridge
`default_nettype wire

// *** hdl/cab_edge_sync.sv ***
// Purpose: Synchronise the link clock and flag its rising edges
// Assumes: Link clock well below half of CLK_SYS
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module cab_edge_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Raw level and edge pulse
    input wire logic async_in,
    output logic rise
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;
    logic rise_reg;
    logic rise_next;

    always_comb
    begin
        sh_next = {sh_reg[1:0], async_in};
        rise_next = sh_reg[1] & ~sh_reg[2];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sh_reg <= 3'h0;
            rise_reg <= 1'b0;
        end
        else
        begin
            sh_reg <= sh_next;
            rise_reg <= rise_next;
        end
    end

    assign rise = rise_reg;
endmodule // cab_edge_sync
`default_nettype wire

// *** hdl/cab_pkg.sv ***
// Purpose: Shared constants and types of the command to APB bridge
// Assumes: Local registers sit at REG_BASE plus their offsets
// Notes: Bus cycles are rising edges of the sampled link clock
`default_nettype none
package cab_pkg;
    // Address map
    localparam logic [15:0] REG_BASE = 16'h0000;
    localparam logic [15:0] BRIDGE_START = 16'h1000;
    localparam logic [15:0] OFS_STATUS = 16'h00d0;
    localparam logic [15:0] OFS_TARDY = 16'h00d1;
    localparam logic [15:0] OFS_TMO = 16'h00d2;
    localparam logic [15:0] OFS_ADDR_LO = 16'h00d4;
    localparam logic [15:0] OFS_ADDR_HI = 16'h00d5;
    localparam logic [15:0] OFS_FETCHED = 16'h00d8;
    // Field positions
    localparam int TMO_DIS_BIT = 3;
    localparam int TMO_SEL_MSB = 2;
    localparam int TARDY_MSB = 1;
    // Reset values
    localparam logic [1:0] TARDY_RST = 2'h1;
    localparam logic TMO_DIS_RST = 1'b0;
    localparam logic [2:0] TMO_SEL_RST = 3'h0;
    // Answer codes, same encoding as the tardy answer field
    localparam logic [1:0] ANS_IGNORED = 2'h0;
    localparam logic [1:0] ANS_OK = 2'h1;
    localparam logic [1:0] ANS_FAIL = 2'h2;
    localparam logic [1:0] ANS_RSVD = 2'h3;
    // Timing counts in bus cycles
    localparam logic [15:0] RESP_WIN_BUS = 16'h0004;
    localparam logic [15:0] TMO_BASE_BUS = 16'h0008;
    localparam logic [15:0] TMO_MAX_BUS = 16'hffff;
    localparam logic [2:0] TMO_SEL_MAX = 3'h7;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS} cab_state_type;
endpackage
`default_nettype wire

// *** test/cab_apb_slave.sv ***
// Purpose: APB completer standing behind the bridge
// Assumes: Same clock as the bridge; delay 8'hff never answers
// Notes: Read data is address derived so the bench can predict it
`timescale 1ns/1ps
`default_nettype none
module cab_apb_slave
(
    // Clock
    input wire logic clk,
    // APB completer side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [7:0] pwdata,
    output logic [7:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bench control
    input wire logic [7:0] delay,
    input wire logic err,
    output logic [7:0] wdata_seen
);
    logic [7:0] wait_cnt = 8'h00;
    initial prdata = 8'h5a;
    initial pready = 1'b0;
    initial pslverr = 1'b0;
    initial wdata_seen = 8'h00;
    always @(posedge clk)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        // Released data toggles so stale bytes never look valid
        prdata <= ~prdata;
        if (psel && penable && !pready)
        begin
            wait_cnt <= wait_cnt + 8'h01;
            if (wait_cnt >= delay && delay != 8'hff)
            begin
                pready <= 1'b1;
                pslverr <= err;
                prdata <= paddr[7:0] ^ paddr[15:8];
                if (pwrite)
                    wdata_seen <= pwdata;
            end
        end
        else
            wait_cnt <= 8'h00;
    end
endmodule // cab_apb_slave
`default_nettype wire

// *** test/cab_bridge_test.sv ***
// Purpose: Self-checking bench of the command to APB bridge
// Assumes: Commands at falling edges, one outstanding read at a time
// Notes: Timeout limit for code 111 shortened to 32 bus cycles
`timescale 1ns/1ps
`default_nettype none
module cab_bridge_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic sw_clk = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [7:0] cmd_wdata = 8'h00;
    logic ans_valid, late_evt, tmo_evt, psel, penable, pwrite, pready, pslverr;
    logic [1:0] ans_code;
    logic [7:0] ans_rdata, pwdata, prdata, wdata_seen;
    logic [15:0] paddr;
    logic [7:0] delay = 8'h00;
    logic err = 1'b0;
    logic [10:0] exp_q[$];
    logic [10:0] exp_e;
    logic [15:0] a;
    logic [7:0] d;
    int failures = 0;
    int n_checks = 0;
    int n_ans = 0;
    int n_late = 0;
    int n_tmo = 0;
    int t, lim, seed;
    always #25 clk_sys = ~clk_sys;
    // Link clock free running, phase unrelated to the system clock
    initial
    begin
        #37;
        forever #200 sw_clk = ~sw_clk;
    end
    cab_bridge #(.TMO_MAX(16'h0020)) dut_u (.CLK_SYS(clk_sys), .SRST(srst), .SW_CLK(sw_clk),
        .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
        .CMD_WDATA(cmd_wdata), .ANS_VALID(ans_valid), .ANS_CODE(ans_code),
        .ANS_RDATA(ans_rdata), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LATE_EVT(late_evt), .TIMEOUT_EVT(tmo_evt));
    cab_apb_slave apb_u (.clk(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .delay(delay), .err(err), .wdata_seen(wdata_seen));
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [10:0] e(input logic [1:0] c, input logic [7:0] v);
        return {1'b1, c, v};
    endfunction
    function automatic logic [7:0] fdat(input logic [15:0] x);
        return x[7:0] ^ x[15:8];
    endfunction
    // Issue one command, note its answer, wait for it under a bound
    task automatic cmd(input logic wr, input logic [15:0] ad, input logic [7:0] wd,
        input logic [10:0] ex);
        int seen;
        int i;
        @(negedge clk_sys);
        seen = n_ans;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = ad;
        cmd_wdata = wd;
        exp_q.push_back(ex);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        for (i = 0; i < 400 && n_ans == seen; i++)
            @(negedge clk_sys);
        if (n_ans == seen)
        begin
            failures++;
            conclude();
        end
    endtask
    task automatic lr(input logic [15:0] o, input logic [7:0] v);
        cmd(1'b0, cab_pkg::REG_BASE + o, 8'h00, e(cab_pkg::ANS_OK, v));
    endtask
    task automatic lw(input logic [15:0] o, input logic [7:0] v);
        cmd(1'b1, cab_pkg::REG_BASE + o, v, e(cab_pkg::ANS_OK, 8'h00));
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 400 && psel !== 1'b0; i++)
            @(negedge clk_sys);
        check("psel idle", {15'h0, psel}, 16'h0000);
        if (psel !== 1'b0)
            conclude();
    endtask
    // Answer monitor takes the oldest note per answer
    // Falling edge, so registered outputs are settled when looked at
    always @(negedge clk_sys)
    begin
        if (ans_valid === 1'b1)
        begin
            n_ans++;
            if (exp_q.size() == 0)
                check("unexpected answer", 16'h0001, 16'h0000);
            else
            begin
                exp_e = exp_q.pop_front();
                check("answer code", {14'h0, ans_code}, {14'h0, exp_e[9:8]});
                if (exp_e[10])
                    check("answer data", {8'h0, ans_rdata}, {8'h0, exp_e[7:0]});
            end
        end
        if (late_evt === 1'b1)
            n_late++;
        if (tmo_evt === 1'b1)
            n_tmo++;
    end
    initial
    begin
        seed = $urandom(32'h3bb8);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        repeat (4) @(negedge clk_sys);
        // Reset values and reserved bits
        lr(cab_pkg::OFS_STATUS, 8'h00);
        lr(cab_pkg::OFS_TARDY, 8'h01);
        lr(cab_pkg::OFS_TMO, 8'h00);
        lr(cab_pkg::OFS_ADDR_LO, 8'h00);
        lr(cab_pkg::OFS_ADDR_HI, 8'h00);
        lr(cab_pkg::OFS_FETCHED, 8'h00);
        lw(cab_pkg::OFS_TARDY, 8'hfe);
        lr(cab_pkg::OFS_TARDY, 8'h02);
        lw(cab_pkg::OFS_TMO, 8'hf0);
        lr(cab_pkg::OFS_TMO, 8'h00);
        lw(cab_pkg::OFS_TARDY, 8'h01);
        // Direct reads, latch follows the bridge only
        for (int k = 0; k < 3; k++)
        begin
            a = cab_pkg::BRIDGE_START + 16'($urandom % 32'hf000);
            delay = 8'($urandom % 4);
            cmd(1'b0, a, 8'h00, e(cab_pkg::ANS_OK, fdat(a)));
            wait_idle();
            lw(cab_pkg::OFS_ADDR_LO, 8'hff);
            lr(cab_pkg::OFS_ADDR_LO, a[7:0]);
            lr(cab_pkg::OFS_ADDR_HI, a[15:8]);
            lr(cab_pkg::OFS_FETCHED, fdat(a));
            lr(cab_pkg::OFS_STATUS, 8'h02);
        end
        err = 1'b1;
        cmd(1'b0, a, 8'h00, {1'b0, cab_pkg::ANS_FAIL, 8'h00});
        err = 1'b0;
        d = 8'($urandom);
        cmd(1'b1, a, d, e(cab_pkg::ANS_OK, 8'h00));
        wait_idle();
        check("apb write data", {8'h0, wdata_seen}, {8'h0, d});
        // Late reads under each tardy code, timeout off
        lw(cab_pkg::OFS_TMO, 8'h08);
        delay = 8'd100;
        for (int c = 0; c < 4; c++)
        begin
            lw(cab_pkg::OFS_TARDY, 8'(c));
            a = cab_pkg::BRIDGE_START + 16'($urandom % 32'hf000);
            cmd(1'b0, a, 8'h00, e(c == 3 ? cab_pkg::ANS_FAIL : 2'(c), 8'h00));
            cmd(1'b0, a, 8'h00, {1'b0, cab_pkg::ANS_FAIL, 8'h00});
            wait_idle();
            lr(cab_pkg::OFS_STATUS, 8'h0b);
            lr(cab_pkg::OFS_ADDR_LO, a[7:0]);
            cmd(1'b0, a, 8'h00, e(cab_pkg::ANS_OK, fdat(a)));
            lr(cab_pkg::OFS_STATUS, 8'h08);
        end
        check("late events", 16'(n_late), 16'd4);
        check("timeouts while off", 16'(n_tmo), 16'd0);
        // Every timeout code; each next write proves the bridge was freed
        delay = 8'hff;
        for (int s = 0; s < 8; s++)
        begin
            lim = (s == 7) ? 32 * 8 : (8 << s) * 8;
            lw(cab_pkg::OFS_TMO, 8'(s));
            cmd(1'b1, cab_pkg::BRIDGE_START, 8'h3c, e(cab_pkg::ANS_OK, 8'h00));
            t = n_tmo;
            for (lim = lim + 12; lim > 0 && n_tmo == t; lim--)
                @(negedge clk_sys);
            check("timeout window", {15'h0, lim > 0 && lim <= 24}, 16'h0001);
            check("psel after timeout", {15'h0, psel}, 16'h0000);
            if (lim == 0)
                conclude();
        end
        delay = 8'h00;
        cmd(1'b0, a, 8'h00, e(cab_pkg::ANS_OK, fdat(a)));
        conclude();
    end
endmodule // cab_bridge_test
`default_nettype wire
